// ==== acc_pkg.sv ====
// constants for the converter conversion-control block
package acc_pkg;
	// ****************************************
	// register addresses and reset values
	// ****************************************
	localparam logic [7:0] ADDR_MODE     = 8'hd8;
	localparam logic [7:0] ADDR_TIMING   = 8'hef;
	localparam logic [7:0] RST_MODE      = 8'h00;
	localparam logic [7:0] RST_TIMING    = 8'h00;
	// ****************************************
	// field positions, mode register
	// ****************************************
	localparam int         BIT_DONE      = 7;
	localparam int         BIT_DMA       = 6;
	localparam int         BIT_CONT      = 5;
	localparam int         BIT_SINGLE    = 4;
	// ****************************************
	// field positions, timing register
	// ****************************************
	localparam int         BIT_POWER     = 7;
	localparam int         BIT_EXTREF    = 6;
	localparam int         BIT_CK_HI     = 5;
	localparam int         BIT_CK_LO     = 4;
	localparam int         BIT_AQ_HI     = 3;
	localparam int         BIT_AQ_LO     = 2;
	localparam int         BIT_T2C       = 1;
	localparam int         BIT_EXC       = 0;
	// ****************************************
	// divider ratios and conversion length
	// ****************************************
	localparam logic [5:0] DIV_CODE_00   = 6'h04;
	localparam logic [5:0] DIV_CODE_01   = 6'h08;
	localparam logic [5:0] DIV_CODE_10   = 6'h10;
	localparam logic [5:0] DIV_CODE_11   = 6'h20;
	localparam logic [3:0] CONV_CLKS     = 4'h0f;
endpackage

// ==== acc_conv_ctrl.sv ====
// top of the converter conversion-control block
`timescale 1ns/100ps
module acc_conv_ctrl (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	// special function register byte access
	input  wire logic [7:0]  sfr_addr,
	input  wire logic        sfr_wr,
	input  wire logic [7:0]  sfr_wdata,
	output logic      [7:0]  sfr_rdata,
	// special function register bit access
	input  wire logic        sfr_bit_wr,
	input  wire logic [7:0]  sfr_bit_addr,
	input  wire logic        sfr_bit_val,
	// start sources and interrupt vector
	input  wire logic        timer2_overflow,
	input  wire logic        convert_start_pin_n,
	input  wire logic        vector_ack,
	// dma sequencer
	input  wire logic        dma_conv_req,
	input  wire logic        dma_done,
	input  wire logic [3:0]  dma_channel_id,
	output logic             dma_start,
	// address-latch strobe
	input  wire logic        ale_in,
	output logic             ale_out,
	// analog converter
	input  wire logic [11:0] adc_code,
	output logic             converter_power_down,
	output logic             use_external_ref,
	output logic             adc_clk_en,
	output logic             track_hold,
	output logic             converting,
	output logic      [3:0]  conv_channel,
	// results and flag
	output logic      [7:0]  result_high_byte,
	output logic      [7:0]  result_low_byte,
	output logic             conversion_done_flag
);

	// ****************************************
	// state and registers
	// ****************************************
	typedef enum logic [1:0] {ACC_IDLE, ACC_ACQ, ACC_CONV} acc_state_t;

	acc_state_t  state;
	logic [7:0]  timing;
	logic [3:0]  channel_select_field;
	logic        continuous_convert_bit;
	logic        single_convert_bit;
	logic        dma_enable;
	logic [5:0]  div_cnt;
	logic [3:0]  seq_cnt;
	logic        pin_prev;
	logic [7:0]  wr2_en;
	logic [7:0]  wr2_val;
	logic [3:0]  next_channel;
	logic [5:0]  div_ratio;
	logic        powered;
	logic        single_go;
	logic        start;
	logic        conv_end;
	logic        pin_fall;

	// ****************************************
	// register writes, byte and bit
	// ****************************************
	always_comb begin
		wr2_en  = 8'h00;
		wr2_val = 8'h00;
		if (sfr_wr && sfr_addr == acc_pkg::ADDR_MODE) begin
			wr2_en  = 8'hff;
			wr2_val = sfr_wdata;
		end else if (sfr_bit_wr && sfr_bit_addr[7:3] == acc_pkg::ADDR_MODE[7:3]) begin
			wr2_en[sfr_bit_addr[2:0]]  = 1'b1;
			wr2_val[sfr_bit_addr[2:0]] = sfr_bit_val;
		end
	end

	// outside dma mode, a write that also starts a conversion must convert the channel it writes
	assign next_channel = (wr2_val[3:0] & wr2_en[3:0]) | (channel_select_field & ~wr2_en[3:0]);

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			timing <= acc_pkg::RST_TIMING;
		end else if (sfr_wr && sfr_addr == acc_pkg::ADDR_TIMING) begin
			timing <= sfr_wdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			channel_select_field   <= acc_pkg::RST_MODE[3:0];
			continuous_convert_bit <= acc_pkg::RST_MODE[acc_pkg::BIT_CONT];
		end else begin
			channel_select_field <= next_channel;
			if (wr2_en[acc_pkg::BIT_CONT]) begin
				continuous_convert_bit <= wr2_val[acc_pkg::BIT_CONT];
			end
		end
	end

	// ****************************************
	// power, reference and start qualifiers
	// ****************************************
	assign powered   = timing[acc_pkg::BIT_POWER];
	assign single_go = wr2_en[acc_pkg::BIT_SINGLE] && wr2_val[acc_pkg::BIT_SINGLE]
		&& !single_convert_bit;
	assign pin_fall  = pin_prev && !convert_start_pin_n;
	// sources are only looked at in idle, so a busy converter never restarts
	assign start     = state == ACC_IDLE && powered && (
		single_go
		|| (continuous_convert_bit && !dma_enable)
		|| (timing[acc_pkg::BIT_T2C] && timer2_overflow)
		|| (timing[acc_pkg::BIT_EXC] && pin_fall)
		|| (dma_enable && dma_conv_req));
	assign conv_end  = state == ACC_CONV && adc_clk_en && seq_cnt == 4'h0;

	// pin is synchronous; one previous sample finds the falling edge
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			pin_prev <= 1'b1;
		end else begin
			pin_prev <= convert_start_pin_n;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			converter_power_down <= 1'b1;
			use_external_ref     <= 1'b0;
		end else begin
			converter_power_down <= !powered;
			use_external_ref     <= timing[acc_pkg::BIT_EXTREF];
		end
	end

	// ****************************************
	// converter clock divider
	// ****************************************
	always_comb begin
		case (timing[acc_pkg::BIT_CK_HI:acc_pkg::BIT_CK_LO])
			2'b00:   div_ratio = acc_pkg::DIV_CODE_00;
			2'b01:   div_ratio = acc_pkg::DIV_CODE_01;
			2'b10:   div_ratio = acc_pkg::DIV_CODE_10;
			default: div_ratio = acc_pkg::DIV_CODE_11;
		endcase
	end

	// a ratio change takes effect at once, mid-period; a count already past the new ratio wraps on the next cycle
	always_ff @(posedge ref_clk) begin
		if (!resetn || !powered) begin
			div_cnt    <= 6'h00;
			adc_clk_en <= 1'b0;
		end else if (div_cnt >= div_ratio - 6'h01) begin
			div_cnt    <= 6'h00;
			adc_clk_en <= 1'b1;
		end else begin
			div_cnt    <= div_cnt + 6'h01;
			adc_clk_en <= 1'b0;
		end
	end

	// ****************************************
	// acquisition and conversion sequence
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			state   <= ACC_IDLE;
			seq_cnt <= 4'h0;
		end else if (!powered) begin
			state   <= ACC_IDLE;
			seq_cnt <= 4'h0;
		end else begin
			case (state)
				ACC_IDLE: begin
					if (start) begin
						state   <= ACC_ACQ;
						seq_cnt <= {2'b00, timing[acc_pkg::BIT_AQ_HI:acc_pkg::BIT_AQ_LO]};
					end
				end
				ACC_ACQ: begin
					if (adc_clk_en) begin
						if (seq_cnt == 4'h0) begin
							state   <= ACC_CONV;
							seq_cnt <= acc_pkg::CONV_CLKS - 4'h1;
						end else begin
							seq_cnt <= seq_cnt - 4'h1;
						end
					end
				end
				ACC_CONV: begin
					if (adc_clk_en) begin
						if (seq_cnt == 4'h0) begin
							state <= ACC_IDLE;
						end else begin
							seq_cnt <= seq_cnt - 4'h1;
						end
					end
				end
				default: begin
					state <= ACC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			track_hold <= 1'b0;
			converting <= 1'b0;
		end else begin
			track_hold <= state == ACC_ACQ && !(adc_clk_en && seq_cnt == 4'h0);
			converting <= (state == ACC_ACQ && adc_clk_en && seq_cnt == 4'h0)
				|| (state == ACC_CONV && !conv_end);
		end
	end

	// channel is frozen at start so later writes cannot disturb a conversion
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			conv_channel <= 4'h0;
		end else if (start) begin
			conv_channel <= dma_enable ? dma_channel_id : next_channel;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			result_high_byte <= 8'h00;
			result_low_byte  <= 8'h00;
		end else if (conv_end) begin
			result_high_byte <= {conv_channel, adc_code[11:8]};
			result_low_byte  <= adc_code[7:0];
		end
	end

	// ****************************************
	// single, dma and done bits
	// ****************************************
	// a single request is only stored when it is really taken
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			single_convert_bit <= acc_pkg::RST_MODE[acc_pkg::BIT_SINGLE];
		end else if (single_go && start) begin
			single_convert_bit <= 1'b1;
		end else if (conv_end || !powered) begin
			single_convert_bit <= 1'b0;
		end else if (wr2_en[acc_pkg::BIT_SINGLE] && !wr2_val[acc_pkg::BIT_SINGLE]) begin
			single_convert_bit <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			dma_enable <= acc_pkg::RST_MODE[acc_pkg::BIT_DMA];
			dma_start  <= 1'b0;
		end else begin
			dma_start <= 1'b0;
			if (dma_done) begin
				dma_enable <= 1'b0;
			end else if (wr2_en[acc_pkg::BIT_DMA]) begin
				dma_enable <= wr2_val[acc_pkg::BIT_DMA];
				dma_start  <= wr2_val[acc_pkg::BIT_DMA] && !dma_enable;
			end
		end
	end

	// strobe held low while dma mode is enabled; the bus belongs to the dma engine then
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ale_out <= 1'b0;
		end else begin
			ale_out <= ale_in && !dma_enable;
		end
	end

	// hardware set beats any clear in the same cycle
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			conversion_done_flag <= acc_pkg::RST_MODE[acc_pkg::BIT_DONE];
		end else if ((conv_end && !dma_enable) || dma_done) begin
			conversion_done_flag <= 1'b1;
		end else if (vector_ack) begin
			conversion_done_flag <= 1'b0;
		end else if (wr2_en[acc_pkg::BIT_DONE]) begin
			conversion_done_flag <= wr2_val[acc_pkg::BIT_DONE];
		end
	end

	// ****************************************
	// register read
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_addr == acc_pkg::ADDR_MODE) begin
			sfr_rdata <= {conversion_done_flag, dma_enable, continuous_convert_bit,
				single_convert_bit, channel_select_field};
		end else if (sfr_addr == acc_pkg::ADDR_TIMING) begin
			sfr_rdata <= timing;
		end else begin
			sfr_rdata <= 8'h00;
		end
	end

endmodule

// ==== acc_conv_ctrl_checker.sv ====
// assertions for the conversion-control block, bound to its top
`timescale 1ns/100ps
module acc_conv_ctrl_checker (
	// clock, reset and register bus
	input wire logic       ref_clk,
	input wire logic       resetn,
	input wire logic [7:0] sfr_addr,
	input wire logic       sfr_wr,
	input wire logic       sfr_bit_wr,
	input wire logic [7:0] sfr_wdata,
	// events in
	input wire logic       vector_ack,
	input wire logic       dma_done,
	// outputs watched
	input wire logic       dma_start,
	input wire logic       ale_out,
	input wire logic       adc_clk_en,
	input wire logic       track_hold,
	input wire logic       converting,
	input wire logic [3:0] conv_channel,
	input wire logic [7:0] result_high_byte,
	input wire logic       converter_power_down,
	input wire logic       use_external_ref,
	input wire logic       conversion_done_flag
);
	// ****
	// properties
	// ****
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	wire t_wr = sfr_wr && sfr_addr == 8'hef;
	a_power_follow: assert property (t_wr |-> ##2 converter_power_down == !$past(sfr_wdata[7], 2))
		else $error("power state does not follow write");
	a_ref_follow: assert property (t_wr |-> ##2 use_external_ref == $past(sfr_wdata[6], 2))
		else $error("reference select does not follow write");
	a_clk_spacing: assert property (adc_clk_en |=> !adc_clk_en [*3])
		else $error("converter clock pulses too close");
	a_phase_exclusive: assert property (!(track_hold && converting))
		else $error("acquire and convert overlap");
	a_dma_pulse: assert property (dma_start |=> !dma_start)
		else $error("dma start not a single pulse");
	a_strobe_quiet: assert property (dma_start |=> !ale_out)
		else $error("strobe toggles in dma mode");
	// a set source in the same cycle wins and writes are excluded as well, so only the clean case is judged
	a_flag_vector: assert property (vector_ack && !dma_done && !sfr_wr && !sfr_bit_wr
		&& !converting |=> !conversion_done_flag)
		else $error("flag not cleared on vector");
	a_result_channel: assert property ($fell(converting) && !converter_power_down
		|-> result_high_byte[7:4] == conv_channel)
		else $error("result channel nibble wrong");
	a_channel_hold: assert property (converting && $past(converting) |-> $stable(conv_channel))
		else $error("channel changed in mid conversion");
	c_dma: cover property (dma_start);
	c_end: cover property ($fell(converting));
	c_vector: cover property (vector_ack && conversion_done_flag);
endmodule

bind acc_conv_ctrl acc_conv_ctrl_checker u_chk (.*);

// ==== acc_conv_ctrl_test.sv ====
// self-checking bench for the conversion-control block
`timescale 1ns/100ps
module acc_conv_ctrl_test;
	// ****
	// signals
	// ****
	logic        ref_clk = 0, resetn = 0, sfr_wr = 0, sfr_bit_wr = 0, sfr_bit_val = 0;
	logic        timer2_overflow = 0, convert_start_pin_n = 1, vector_ack = 0;
	logic        dma_conv_req = 0, dma_done = 0, ale_in = 0;
	logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_bit_addr = 8'h00;
	logic [7:0]  sfr_rdata, rhi, rlo;
	logic [3:0]  dma_channel_id = 4'h9, conv_channel;
	logic [11:0] adc_code = 12'habc;
	logic        dma_start, ale_out, cpd, uxr, clk_en, track_hold, converting, flag;
	int          failures = 0, num_checks = 0, th_n = 0, cv_n = 0, ds_n = 0, al_n = 0;
	acc_conv_ctrl dut (
		.ref_clk(ref_clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_bit_wr(sfr_bit_wr),
		.sfr_bit_addr(sfr_bit_addr), .sfr_bit_val(sfr_bit_val),
		.timer2_overflow(timer2_overflow), .convert_start_pin_n(convert_start_pin_n),
		.vector_ack(vector_ack), .dma_conv_req(dma_conv_req), .dma_done(dma_done),
		.dma_channel_id(dma_channel_id), .dma_start(dma_start), .ale_in(ale_in),
		.ale_out(ale_out), .adc_code(adc_code), .converter_power_down(cpd),
		.use_external_ref(uxr), .adc_clk_en(clk_en), .track_hold(track_hold),
		.converting(converting), .conv_channel(conv_channel), .result_high_byte(rhi),
		.result_low_byte(rlo), .conversion_done_flag(flag));
	always #4 ref_clk = ~ref_clk;
	always @(negedge ref_clk) ale_in <= ~ale_in;
	// one-cycle outputs are counted here so no task can miss them
	always @(posedge ref_clk) begin
		th_n <= th_n + (clk_en & track_hold);
		cv_n <= cv_n + (clk_en & converting);
		ds_n <= ds_n + dma_start;
		al_n <= al_n + ale_out;
	end
	// ****
	// tasks
	// ****
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		num_checks++;
		if (s !== e) begin
			failures++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic pulse(ref logic s);
		s = 1;
		cyc(1);
		s = 0;
		cyc(1);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		pulse(sfr_wr);
	endtask
	task automatic bwr(input logic [7:0] a, input logic v);
		sfr_bit_addr = a;
		sfr_bit_val = v;
		pulse(sfr_bit_wr);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		sfr_addr = a;
		cyc(1);
		chk(sfr_rdata, e);
	endtask
	task automatic wpulse;
		for (int i = 0; i < 64 && clk_en !== 1; i++) cyc(1);
	endtask
	task automatic wflag;
		for (int i = 0; i < 2000 && flag !== 1; i++) cyc(1);
		chk(flag, 1);
	endtask
	task automatic fire(input bit pin);
		if (pin) begin
			convert_start_pin_n = 0;
			cyc(14);
			convert_start_pin_n = 1;
		end else begin
			pulse(timer2_overflow);
		end
	endtask
	// ****
	// tests
	// ****
	initial begin
		#100000;
		failures++;
		tally_and_finish;
	end
	initial begin
		int n;
		cyc(20);
		resetn = 1;
		rd(8'hd8, 8'h00);
		rd(8'hef, 8'h00);
		rd(8'h55, 8'h00);
		chk(cpd, 1);
		$display("reset test done");
		for (int k = 0; k < 4; k++) begin
			wr(8'hef, 8'hc0 | 8'(k << 4));
			chk(cpd, 0);
			chk(uxr, 1);
			cyc(2);
			wpulse;
			n = 0;
			do begin cyc(1); n++; end while (clk_en !== 1 && n < 64);
			chk(16'(n), 16'(4 << k));
		end
		$display("divider test done");
		for (int q = 0; q < 4; q++) begin
			wr(8'hef, 8'h80 | 8'(q << 2));
			wpulse;
			th_n = 0;
			cv_n = 0;
			wr(8'hd8, 8'h10 | 8'(q * 5));
			wflag;
			chk(16'(th_n), 16'(q + 1));
			chk(16'(cv_n), 16'h000f);
			chk({rhi, rlo}, 16'(q * 5) << 12 | 16'h0abc);
			rd(8'hd8, 8'h80 | 8'(q * 5));
			pulse(vector_ack);
			rd(8'hd8, 8'(q * 5));
		end
		$display("single test done");
		for (int k = 0; k < 4; k++) begin
			wr(8'hef, k[0] ? (k[1] ? 8'h81 : 8'h82) : 8'h80);
			fire(k[1]);
			cyc(4);
			chk(track_hold | converting, k[0]);
			if (k[0]) begin
				fire(k[1]);
				wflag;
				pulse(vector_ack);
				cyc(4);
				chk(track_hold | converting, 0);
			end
		end
		$display("trigger test done");
		wr(8'hef, 8'h88);
		wr(8'hd8, 8'h23);
		wflag;
		bwr(8'hdf, 0);
		cyc(3);
		chk(track_hold | converting, 1);
		rd(8'hd8, 8'h23);
		wr(8'hd8, 8'h03);
		wflag;
		cyc(4);
		chk(track_hold | converting, 0);
		$display("continuous test done");
		ds_n = 0;
		wr(8'hd8, 8'h40);
		chk(16'(ds_n), 1);
		al_n = 0;
		cyc(16);
		chk(16'(al_n), 0);
		pulse(dma_conv_req);
		chk(conv_channel, 4'h9);
		cyc(80);
		pulse(dma_done);
		rd(8'hd8, 8'h80);
		al_n = 0;
		cyc(8);
		chk(16'(al_n), 4);
		$display("dma test done");
		wr(8'hef, 8'h00);
		cyc(2);
		chk(cpd, 1);
		chk(uxr, 0);
		wr(8'hd8, 8'h10);
		rd(8'hd8, 8'h00);
		$display("power test done");
		tally_and_finish;
	end
endmodule
